/* core/pws_window_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module pws_window_regs #(
  parameter int PIX_W = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic [11:0] man_h_offset,
  input wire logic [11:0] man_v_offset,
  input wire logic [11:0] auto_h_offset,
  input wire logic [11:0] auto_v_offset,
  input wire logic [2:0] auto_ratio,
  input wire logic [4:0] auto_h_skip,
  input wire logic [4:0] auto_v_skip,
  input wire logic [3:0] h_odd_step,
  input wire logic [3:0] v_odd_step,
  input wire logic [3:0] h_even_step,
  input wire logic [3:0] v_even_step,
  input wire logic frame_start,
  input wire logic line_valid,
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_data,
  output logic pix_ready,
  output logic out_valid,
  output logic [PIX_W-1:0] out_data,
  output logic out_first_col,
  output logic out_first_line,
  input wire logic out_ready,
  output logic [2:0] out_dummy_num,
  output logic [2:0] out_ratio,
  output logic out_half
);
  // ----------------------------------------------------------------
  // Host-writable registers.
  // ----------------------------------------------------------------
  logic [7:0] ori_reg, dum_reg, blh_reg, bll_reg, mhs_reg, mvs_reg;
  logic wr_ori, wr_dum, wr_blh, wr_bll, wr_mhs, wr_mvs;

  // Only the six writable addresses decode; anything else is dropped.
  assign wr_ori = reg_wr_en && reg_addr == pws_pkg::A_ORI;
  assign wr_dum = reg_wr_en && reg_addr == pws_pkg::A_DUM;
  assign wr_blh = reg_wr_en && reg_addr == pws_pkg::A_BLH;
  assign wr_bll = reg_wr_en && reg_addr == pws_pkg::A_BLL;
  assign wr_mhs = reg_wr_en && reg_addr == pws_pkg::A_MHS;
  assign wr_mvs = reg_wr_en && reg_addr == pws_pkg::A_MVS;

  // Array height resets to its nominal full-array value.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ori_reg <= pws_pkg::ORI_RST;
      dum_reg <= pws_pkg::DUM_RST;
      blh_reg <= pws_pkg::BLH_RST;
      bll_reg <= pws_pkg::BLL_RST;
      mhs_reg <= pws_pkg::SKP_RST;
      mvs_reg <= pws_pkg::SKP_RST;
    end else begin
      if (wr_ori) ori_reg <= reg_wr_data;
      if (wr_dum) dum_reg <= reg_wr_data;
      if (wr_blh) blh_reg <= {4'h0, reg_wr_data[3:0]};
      if (wr_bll) bll_reg <= reg_wr_data;
      if (wr_mhs) mhs_reg <= {2'h0, reg_wr_data[5:0]};
      if (wr_mvs) mvs_reg <= {2'h0, reg_wr_data[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // Settings in use.
  // ----------------------------------------------------------------
  logic [11:0] sens_h, sens_v, win_h, win_v, bl_height;
  logic h_shift, v_shift, h_phase, v_phase;
  logic [2:0] ratio_used;
  logic [4:0] h_skip, v_skip;

  // Host offsets override the derived ones when manual mode is set.
  assign sens_h = ori_reg[pws_pkg::O_OFSMAN] ? man_h_offset : auto_h_offset;
  assign sens_v = ori_reg[pws_pkg::O_OFSMAN] ? man_v_offset : auto_v_offset;
  // Keeping the unmirrored colour position costs one pixel of offset,
  // and the X option decides whether that step is taken.
  assign h_shift = ori_reg[pws_pkg::O_XOPT] && ori_reg[pws_pkg::O_NOMIR]
                   && ori_reg[pws_pkg::O_MIR];
  assign v_shift = ori_reg[pws_pkg::O_YOPT] && ori_reg[pws_pkg::O_NOFLP]
                   && ori_reg[pws_pkg::O_FLP];
  assign win_h = sens_h + {11'h000, h_shift};
  assign win_v = sens_v + {11'h000, v_shift};
  // Alignment bits force the colour phase of an unmirrored image.
  assign h_phase = ori_reg[pws_pkg::O_NOMIR] ? 1'b0 : ori_reg[pws_pkg::O_MIR];
  assign v_phase = ori_reg[pws_pkg::O_NOFLP] ? 1'b0 : ori_reg[pws_pkg::O_FLP];
  assign ratio_used = dum_reg[pws_pkg::D_MAN] ? dum_reg[2:0] : auto_ratio;
  assign h_skip = mhs_reg[pws_pkg::S_EN] ? mhs_reg[4:0] : auto_h_skip;
  assign v_skip = mvs_reg[pws_pkg::S_EN] ? mvs_reg[4:0] : auto_v_skip;
  assign bl_height = {blh_reg[3:0], bll_reg};

  // ----------------------------------------------------------------
  // Line tracking and measurement.
  // ----------------------------------------------------------------
  pws_pkg::pws_line_e st_reg, st_next;
  logic [12:0] h_cnt_reg, ow_cnt_reg, out_w_reg;
  logic [11:0] v_cnt_reg, oh_cnt_reg, in_pix_reg, in_line_reg, out_h_reg;
  logic [15:0] len_cnt_reg, blank_len_reg, act_len_reg;
  logic [4:0] hs_cnt_reg, vs_cnt_reg;
  logic err_reg, line_has_out_reg;
  logic take, in_win, skip_ok, push, line_end, line_begin, err_hit;

  assign take = pix_valid && pix_ready && line_valid;
  assign in_win = (h_cnt_reg >= {1'b0, win_h}) && (v_cnt_reg >= win_v);
  assign skip_ok = (hs_cnt_reg == 5'd0) && (vs_cnt_reg == 5'd0);
  assign push = take && in_win && skip_ok;
  assign line_end = (st_reg == pws_pkg::S_LINE) && !line_valid;
  assign line_begin = (st_reg != pws_pkg::S_LINE) && line_valid;
  // A blank shorter than one ratio period cannot hold a dummy line.
  assign err_hit = line_begin && (st_reg == pws_pkg::S_BLANK)
                   && (dum_reg[6:4] != 3'd0)
                   && (len_cnt_reg < (16'd1 << ratio_used));

  always_comb begin
    case (st_reg)
      pws_pkg::S_IDLE: st_next = line_valid ? pws_pkg::S_LINE : pws_pkg::S_IDLE;
      pws_pkg::S_LINE: st_next = line_valid ? pws_pkg::S_LINE : pws_pkg::S_BLANK;
      pws_pkg::S_BLANK: st_next = line_valid ? pws_pkg::S_LINE : pws_pkg::S_BLANK;
      default: st_next = pws_pkg::S_IDLE;
    endcase
  end

  // Length counter restarts on each edge of line valid.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= pws_pkg::S_IDLE;
      len_cnt_reg <= 16'h0000;
      blank_len_reg <= 16'h0000;
      act_len_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      len_cnt_reg <= (line_end || line_begin) ? 16'h0001 : len_cnt_reg + 16'h0001;
      if (line_end) act_len_reg <= len_cnt_reg;
      if (line_begin && st_reg == pws_pkg::S_BLANK) blank_len_reg <= len_cnt_reg;
    end
  end

  // Pixel and skip counters within one line.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      h_cnt_reg <= 13'h0000;
      hs_cnt_reg <= 5'h00;
      ow_cnt_reg <= 13'h0000;
      in_pix_reg <= 12'h000;
      out_w_reg <= 13'h0000;
    end else if (line_end) begin
      h_cnt_reg <= 13'h0000;
      hs_cnt_reg <= 5'h00;
      ow_cnt_reg <= 13'h0000;
      in_pix_reg <= h_cnt_reg[11:0];
      if (ow_cnt_reg != 13'h0000) out_w_reg <= ow_cnt_reg;
    end else if (take) begin
      h_cnt_reg <= h_cnt_reg + 13'h0001;
      if (h_cnt_reg >= {1'b0, win_h}) begin
        hs_cnt_reg <= (hs_cnt_reg >= h_skip) ? 5'h00 : hs_cnt_reg + 5'h01;
      end
      if (push) ow_cnt_reg <= ow_cnt_reg + 13'h0001;
    end
  end

  // Line counters within one frame; frame start latches the totals.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      v_cnt_reg <= 12'h000;
      vs_cnt_reg <= 5'h00;
      oh_cnt_reg <= 12'h000;
      in_line_reg <= 12'h000;
      out_h_reg <= 12'h000;
      line_has_out_reg <= 1'b0;
    end else if (frame_start) begin
      v_cnt_reg <= 12'h000;
      vs_cnt_reg <= 5'h00;
      oh_cnt_reg <= 12'h000;
      in_line_reg <= v_cnt_reg;
      out_h_reg <= oh_cnt_reg;
      line_has_out_reg <= 1'b0;
    end else begin
      if (push) line_has_out_reg <= 1'b1;
      if (line_end) begin
        v_cnt_reg <= v_cnt_reg + 12'h001;
        line_has_out_reg <= 1'b0;
        if (line_has_out_reg || push) oh_cnt_reg <= oh_cnt_reg + 12'h001;
        if (v_cnt_reg >= win_v) begin
          vs_cnt_reg <= (vs_cnt_reg >= v_skip) ? 5'h00 : vs_cnt_reg + 5'h01;
        end
      end
    end
  end

  // The error flag holds for the rest of the frame; a new hit in the
  // frame-start cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_reg <= 1'b0;
    end else if (err_hit) begin
      err_reg <= 1'b1;
    end else if (frame_start) begin
      err_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pixel path through the two-entry buffer.
  // ----------------------------------------------------------------
  logic [PIX_W+1:0] buf_out;

  pws_skid_buf #(
    .W(PIX_W + 2)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data({v_phase, h_phase, pix_data}),
    .in_ready(pix_ready),
    .out_valid(out_valid),
    .out_data(buf_out),
    .out_ready(out_ready)
  );

  assign out_data = buf_out[PIX_W-1:0];
  assign out_first_col = buf_out[PIX_W];
  assign out_first_line = buf_out[PIX_W+1];

  // Dummy line controls to the timing stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_dummy_num <= 3'h0;
      out_ratio <= 3'h0;
      out_half <= 1'b0;
    end else begin
      out_dummy_num <= dum_reg[6:4];
      out_ratio <= ratio_used;
      out_half <= dum_reg[pws_pkg::D_HALF];
    end
  end

  // ----------------------------------------------------------------
  // Read-back.
  // ----------------------------------------------------------------
  logic [15:0] blank_rep;
  logic [11:0] cut_bot;
  logic [7:0] rd_mux;

  // Halving acts on what the host reads, so the raw count stays exact.
  assign blank_rep = dum_reg[pws_pkg::D_HALF] ? {1'b0, blank_len_reg[15:1]} : blank_len_reg;
  assign cut_bot = bl_height - win_v - out_h_reg;

  always_comb begin
    case (reg_addr)
      pws_pkg::A_PIXH: rd_mux = {4'h0, in_pix_reg[11:8]};
      pws_pkg::A_PIXL: rd_mux = in_pix_reg[7:0];
      pws_pkg::A_LINH: rd_mux = {4'h0, in_line_reg[11:8]};
      pws_pkg::A_LINL: rd_mux = in_line_reg[7:0];
      pws_pkg::A_ORI: rd_mux = {ori_reg[7:1], 1'b0};
      pws_pkg::A_DUM: rd_mux = dum_reg;
      pws_pkg::A_BLKH: rd_mux = blank_rep[15:8];
      pws_pkg::A_BLKL: rd_mux = blank_rep[7:0];
      pws_pkg::A_ACTH: rd_mux = act_len_reg[15:8];
      pws_pkg::A_ACTL: rd_mux = act_len_reg[7:0];
      pws_pkg::A_DST: rd_mux = {3'h0, err_reg, 1'b0, ratio_used};
      pws_pkg::A_ODD: rd_mux = {h_odd_step, v_odd_step};
      pws_pkg::A_SHH: rd_mux = {4'h0, sens_h[11:8]};
      pws_pkg::A_SHL: rd_mux = sens_h[7:0];
      pws_pkg::A_SVH: rd_mux = {4'h0, sens_v[11:8]};
      pws_pkg::A_SVL: rd_mux = sens_v[7:0];
      pws_pkg::A_WHH: rd_mux = {4'h0, win_h[11:8]};
      pws_pkg::A_WHL: rd_mux = win_h[7:0];
      pws_pkg::A_WVH: rd_mux = {4'h0, win_v[11:8]};
      pws_pkg::A_WVL: rd_mux = win_v[7:0];
      pws_pkg::A_WDH: rd_mux = {3'h0, out_w_reg[12:8]};
      pws_pkg::A_WDL: rd_mux = out_w_reg[7:0];
      pws_pkg::A_HTH: rd_mux = {4'h0, out_h_reg[11:8]};
      pws_pkg::A_HTL: rd_mux = out_h_reg[7:0];
      pws_pkg::A_SKP: rd_mux = {2'h0, h_skip[1:0], 2'h0, v_skip[1:0]};
      pws_pkg::A_EVN: rd_mux = {h_even_step, v_even_step};
      pws_pkg::A_CTH: rd_mux = {4'h0, win_v[11:8]};
      pws_pkg::A_CTL: rd_mux = win_v[7:0];
      pws_pkg::A_CBH: rd_mux = {4'h0, cut_bot[11:8]};
      pws_pkg::A_CBL: rd_mux = cut_bot[7:0];
      pws_pkg::A_BLH: rd_mux = blh_reg;
      pws_pkg::A_BLL: rd_mux = bll_reg;
      pws_pkg::A_MHS: rd_mux = mhs_reg;
      pws_pkg::A_MVS: rd_mux = mvs_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured one cycle after the strobe and then held.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) reg_rd_data <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  sequence s_rd(logic [15:0] a);
    reg_rd_en && reg_addr == a;
  endsequence

  sequence s_idle_bus;
    !reg_wr_en [*2];
  endsequence

  property p_mirror_col;
    @(posedge clk) disable iff (!rst_n)
    (!ori_reg[pws_pkg::O_NOMIR] && ori_reg[pws_pkg::O_MIR] && push && !out_valid)
      ##0 s_idle_bus |-> out_valid && out_first_col;
  endproperty
  a_mirror_col: assert property (p_mirror_col)
    else $error("mirrored pixel lost its colour tag");

  property p_nomir_col;
    @(posedge clk) disable iff (!rst_n)
    (ori_reg[pws_pkg::O_NOMIR] && push && !out_valid) ##0 s_idle_bus
      |-> out_valid && !out_first_col;
  endproperty
  a_nomir_col: assert property (p_nomir_col)
    else $error("alignment did not restore unmirrored phase");

  property p_flip_line;
    @(posedge clk) disable iff (!rst_n)
    (!ori_reg[pws_pkg::O_NOFLP] && ori_reg[pws_pkg::O_FLP] && push && !out_valid)
      ##0 s_idle_bus |-> out_valid && out_first_line;
  endproperty
  a_flip_line: assert property (p_flip_line)
    else $error("flipped line lost its colour tag");

  property p_man_ofs;
    @(posedge clk) disable iff (!rst_n)
    s_rd(pws_pkg::A_SHL) ##0 ori_reg[pws_pkg::O_OFSMAN]
      |=> reg_rd_valid && reg_rd_data == $past(man_h_offset[7:0]);
  endproperty
  a_man_ofs: assert property (p_man_ofs)
    else $error("manual offset not in use");

  property p_man_ratio;
    @(posedge clk) disable iff (!rst_n)
    dum_reg[pws_pkg::D_MAN] && !reg_wr_en |=> out_ratio == $past(dum_reg[2:0]);
  endproperty
  a_man_ratio: assert property (p_man_ratio)
    else $error("manual dummy ratio ignored");

  property p_half;
    @(posedge clk) disable iff (!rst_n)
    s_rd(pws_pkg::A_BLKL) ##0 dum_reg[pws_pkg::D_HALF]
      |=> reg_rd_data == $past(blank_len_reg[8:1]);
  endproperty
  a_half: assert property (p_half)
    else $error("blank length not halved");

  property p_hskip_rd;
    @(posedge clk) disable iff (!rst_n)
    s_rd(pws_pkg::A_SKP) ##0 mhs_reg[pws_pkg::S_EN]
      |=> reg_rd_data[5:4] == $past(mhs_reg[1:0]);
  endproperty
  a_hskip_rd: assert property (p_hskip_rd)
    else $error("manual horizontal skip not applied");

  property p_pix_count;
    @(posedge clk) disable iff (!rst_n)
    line_end |=> in_pix_reg == $past(h_cnt_reg[11:0]) && h_cnt_reg == 13'h0000;
  endproperty
  a_pix_count: assert property (p_pix_count)
    else $error("input pixel count not latched at line end");

  property p_ro_write;
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && reg_addr == pws_pkg::A_UNU
      |=> $stable(ori_reg) && $stable(dum_reg) && $stable(blh_reg) && $stable(bll_reg);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to unused address changed a register");
endmodule // pws_window_regs
`default_nettype wire

/* core/pws_pkg.sv */
// Function
// - Mirror option picks first output pixel colour: Gb/R when clear, B/Gr when set.
// - Flip option picks first output line order: GR row when clear, BG when set.
// - Offset manual enable selects host offsets instead of derived offsets.
// - No-mirror alignment keeps first pixel where an unmirrored image has it.
// - No-flip alignment keeps first line where an unflipped image has it.
// - Separate X and Y option bits adjust how each window offset applies.
// - Manual ratio enable selects host 3-bit clock/valid ratio for dummy lines.
// - Dummy line count comes from a 3-bit host field.
// - Halving bit cuts the reported line-valid low interval in half.
// - Dummy blank and active lengths read back as 16-bit byte pairs.
// - Dummy error flag and applied 3-bit ratio read back.
// - Measured input pixels per line and lines per frame read back, 12 bits.
// - Sensor offsets in use read back as 12-bit values.
// - Window offsets in use read back as 12-bit values.
// - Output width reads back in 13 bits, height in 12 bits.
// - Horizontal and vertical skip read back as two 2-bit fields.
// - Odd and even increment steps read back as 4-bit fields.
// - Top and bottom cut offsets read back as 12-bit values.
// - Array height is 12-bit read-write, reset high 0x09 low 0xb0.
// - Manual horizontal skip enable applies host 5-bit horizontal skip.
// - Manual vertical skip enable applies host 5-bit vertical skip.
`default_nettype none
package pws_pkg;
  // ----------------------------------------------------------------
  // Register addresses.
  // ----------------------------------------------------------------
  localparam logic [15:0] A_PIXH = 16'h5e0c;
  localparam logic [15:0] A_PIXL = 16'h5e0d;
  localparam logic [15:0] A_LINH = 16'h5e0e;
  localparam logic [15:0] A_LINL = 16'h5e0f;
  localparam logic [15:0] A_ORI = 16'h5e10;
  localparam logic [15:0] A_DUM = 16'h5e11;
  localparam logic [15:0] A_BLKH = 16'h5e12;
  localparam logic [15:0] A_BLKL = 16'h5e13;
  localparam logic [15:0] A_ACTH = 16'h5e14;
  localparam logic [15:0] A_ACTL = 16'h5e15;
  localparam logic [15:0] A_DST = 16'h5e16;
  localparam logic [15:0] A_ODD = 16'h5e17;
  localparam logic [15:0] A_SHH = 16'h5e18;
  localparam logic [15:0] A_SHL = 16'h5e19;
  localparam logic [15:0] A_SVH = 16'h5e1a;
  localparam logic [15:0] A_SVL = 16'h5e1b;
  localparam logic [15:0] A_WHH = 16'h5e1c;
  localparam logic [15:0] A_WHL = 16'h5e1d;
  localparam logic [15:0] A_WVH = 16'h5e1e;
  localparam logic [15:0] A_WVL = 16'h5e1f;
  localparam logic [15:0] A_WDH = 16'h5e20;
  localparam logic [15:0] A_WDL = 16'h5e21;
  localparam logic [15:0] A_HTH = 16'h5e22;
  localparam logic [15:0] A_HTL = 16'h5e23;
  localparam logic [15:0] A_SKP = 16'h5e24;
  localparam logic [15:0] A_EVN = 16'h5e25;
  localparam logic [15:0] A_UNU = 16'h5e26;
  localparam logic [15:0] A_CTH = 16'h5e27;
  localparam logic [15:0] A_CTL = 16'h5e28;
  localparam logic [15:0] A_CBH = 16'h5e29;
  localparam logic [15:0] A_CBL = 16'h5e2a;
  localparam logic [15:0] A_BLH = 16'h5e2b;
  localparam logic [15:0] A_BLL = 16'h5e2c;
  localparam logic [15:0] A_MHS = 16'h5e2d;
  localparam logic [15:0] A_MVS = 16'h5e2e;
  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int O_XOPT = 7;
  localparam int O_YOPT = 6;
  localparam int O_NOMIR = 5;
  localparam int O_NOFLP = 4;
  localparam int O_MIR = 3;
  localparam int O_FLP = 2;
  localparam int O_OFSMAN = 1;
  localparam int D_MAN = 7;
  localparam int D_HALF = 3;
  localparam int S_EN = 5;
  localparam int DST_ERR = 4;
  localparam logic [7:0] ORI_RST = 8'h3c;
  localparam logic [7:0] DUM_RST = 8'h00;
  localparam logic [7:0] BLH_RST = 8'h09;
  localparam logic [7:0] BLL_RST = 8'hb0;
  localparam logic [7:0] SKP_RST = 8'h00;
  localparam int RD_LAT = 1;
  // Line tracking states.
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_LINE = 3'b010,
    S_BLANK = 3'b100
  } pws_line_e;
endpackage
`default_nettype wire

/* core/pws_skid_buf.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Two-entry buffer; entry zero is always the head, so the output
// data comes straight from a flip-flop.
// ------------------------------------------------------------------
module pws_skid_buf #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] e1_reg, e0_next, e1_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Shift the spare entry forward on a pop so the head never moves.
  always_comb begin
    e0_next = out_data;
    e1_next = e1_reg;
    cnt_next = cnt_reg;
    if (pop) begin
      e0_next = (cnt_reg == 2'd2) ? e1_reg : in_data;
    end else if (push && cnt_reg == 2'd0) begin
      e0_next = in_data;
    end
    if (push && !pop && cnt_reg == 2'd1) begin
      e1_next = in_data;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'd1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'd1;
    end
  end

  // Full and valid are kept as flags so the ports are registered.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 2'd0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
      e1_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != 2'd2);
      out_valid <= (cnt_next != 2'd0);
      out_data <= e0_next;
      e1_reg <= e1_next;
    end
  end
endmodule // pws_skid_buf
`default_nettype wire

/* sim/pws_pix_src.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Pixel array readout model.
// ----------------------------------------------------------------
module pws_pix_src (
  input wire logic clk,
  input wire logic pix_ready,
  output logic frame_start,
  output logic line_valid,
  output logic pix_valid,
  output logic [9:0] pix_data
);
  // Idle levels at time zero.
  initial begin
    frame_start = 1'b0;
    line_valid = 1'b0;
    pix_valid = 1'b0;
    pix_data = 10'h2aa;
  end
  // A pixel stays offered until an edge with ready high takes it.
  task automatic send_line(input int n, input logic [9:0] base);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      line_valid = 1'b1;
      pix_valid = 1'b1;
      pix_data = base + 10'(i);
      while (!pix_ready) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    line_valid = 1'b0;
    pix_valid = 1'b0;
    pix_data = ~pix_data; // Junk while idle, so a stale pixel never looks valid.
    repeat (8) @(negedge clk);
  endtask
  // Frame marker lasts one clock.
  task automatic pulse_frame();
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
  endtask
endmodule // pws_pix_src
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Register bank bench.
// ----------------------------------------------------------------
module testbench;
  logic clk, rst_n, wr, rd, out_ready, fs, lv, pv, pr, ov, ofc, ofl, rv, seen, c_col, c_line;
  logic [15:0] addr;
  logic [7:0] wd, rdat;
  logic [11:0] mh, mv, ah, av;
  logic [4:0] hs, vs;
  logic [3:0] ho, vo, he, ve;
  logic [2:0] ar, odn, ort;
  logic oh;
  logic [9:0] pd, od, c_dat;
  int n_fail, num_checks;
  pws_window_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr),
    .reg_wr_data(wd), .reg_rd_en(rd), .reg_rd_data(rdat), .reg_rd_valid(rv),
    .man_h_offset(mh), .man_v_offset(mv), .auto_h_offset(ah), .auto_v_offset(av),
    .auto_ratio(ar), .auto_h_skip(hs), .auto_v_skip(vs), .h_odd_step(ho), .v_odd_step(vo),
    .h_even_step(he), .v_even_step(ve), .frame_start(fs), .line_valid(lv), .pix_valid(pv),
    .pix_data(pd), .pix_ready(pr), .out_valid(ov), .out_data(od), .out_first_col(ofc),
    .out_first_line(ofl), .out_ready(out_ready), .out_dummy_num(odn), .out_ratio(ort),
    .out_half(oh));
  pws_pix_src u_src (.clk(clk), .pix_ready(pr), .frame_start(fs), .line_valid(lv),
    .pix_valid(pv), .pix_data(pd));
  // Keep the tags of the first pixel handed downstream.
  always @(posedge clk) begin
    if (!rst_n) begin
      seen <= 1'b0;
    end else if (ov && out_ready && !seen) begin
      seen <= 1'b1;
      c_col <= ofc;
      c_line <= ofl;
      c_dat <= od;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // The answer stands for one cycle, so it is judged at the next falling edge.
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("reg_rd_valid", 16'h0001, {15'h0000, rv});
    chk("reg_rd_data", {8'h00, e}, {8'h00, rdat});
  endtask
  task automatic t_reset();
    rchk(pws_pkg::A_ORI, 8'h3c);
    rchk(pws_pkg::A_DUM, 8'h00);
    rchk(pws_pkg::A_BLH, 8'h09);
    rchk(pws_pkg::A_BLL, 8'hb0);
    rchk(pws_pkg::A_MVS, 8'h00);
  endtask
  task automatic t_write_rules();
    wreg(pws_pkg::A_BLH, 8'hff);
    rchk(pws_pkg::A_BLH, 8'h0f);
    wreg(pws_pkg::A_ODD, 8'hff);
    rchk(pws_pkg::A_ODD, 8'h3c);
    wreg(pws_pkg::A_UNU, 8'h55);
    rchk(pws_pkg::A_UNU, 8'h00);
    rchk(pws_pkg::A_EVN, 8'h96);
  endtask
  task automatic t_dummy();
    wreg(pws_pkg::A_DUM, 8'hdd);
    @(negedge clk);
    chk("out_dummy_num", 16'h0005, {13'h0000, odn});
    chk("out_ratio", 16'h0005, {13'h0000, ort});
    chk("out_half", 16'h0001, {15'h0000, oh});
    rchk(pws_pkg::A_DST, 8'h05);
    wreg(pws_pkg::A_DUM, 8'h08);
    @(negedge clk);
    chk("out_ratio", 16'h0002, {13'h0000, ort});
    wreg(pws_pkg::A_DUM, 8'h00);
  endtask
  task automatic t_offset_skip();
    rchk(pws_pkg::A_SHH, 8'h00);
    wreg(pws_pkg::A_ORI, 8'h3e);
    rchk(pws_pkg::A_SHL, 8'ha7);
    rchk(pws_pkg::A_SVH, 8'h00);
    rchk(pws_pkg::A_SVL, 8'hc3);
    wreg(pws_pkg::A_ORI, 8'hbe);
    rchk(pws_pkg::A_WHL, 8'ha8);
    wreg(pws_pkg::A_ORI, 8'h0c);
    wreg(pws_pkg::A_MHS, 8'h25);
    wreg(pws_pkg::A_MVS, 8'h23);
    rchk(pws_pkg::A_SKP, 8'h13);
    wreg(pws_pkg::A_MHS, 8'h00);
    wreg(pws_pkg::A_MVS, 8'h00);
  endtask
  // Mirror and flip set with alignment off tag the first pixel and line.
  task automatic t_pixels();
    u_src.pulse_frame();
    u_src.send_line(6, 10'h100);
    u_src.send_line(6, 10'h140);
    rchk(pws_pkg::A_PIXL, 8'h06);
    rchk(pws_pkg::A_ACTL, 8'h06);
    rchk(pws_pkg::A_BLKL, 8'h09);
    rchk(pws_pkg::A_WDL, 8'h06);
    wreg(pws_pkg::A_DUM, 8'h08);
    rchk(pws_pkg::A_BLKL, 8'h04);
    wreg(pws_pkg::A_DUM, 8'h00);
    chk("first_col", 16'h0001, {15'h0000, c_col});
    chk("first_line", 16'h0001, {15'h0000, c_line});
    chk("first_data", 16'h0100, {6'h00, c_dat});
  endtask
  // A stalled receiver must lose no pixel: the head waits and input backs up.
  task automatic t_stall();
    wreg(pws_pkg::A_ORI, 8'h3c);
    out_ready = 1'b0;
    fork
      u_src.send_line(4, 10'h200);
      begin
        repeat (12) @(negedge clk);
        chk("pix_ready", 16'h0000, {15'h0000, pr});
        chk("out_data", 16'h0200, {6'h00, od});
        chk("out_first_col", 16'h0000, {15'h0000, ofc});
        chk("out_first_line", 16'h0000, {15'h0000, ofl});
        out_ready = 1'b1;
      end
    join
    rchk(pws_pkg::A_PIXL, 8'h04);
    u_src.pulse_frame();
    rchk(pws_pkg::A_LINL, 8'h03);
    rchk(pws_pkg::A_HTL, 8'h03);
    rchk(pws_pkg::A_CBL, 8'had);
    rchk(pws_pkg::A_CTL, 8'h00);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang counts as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    {rst_n, wr, rd, addr, wd} = '0;
    {mh, mv, ah, av, ar} = {12'h5a7, 12'h0c3, 12'h000, 12'h000, 3'h2};
    {hs, vs, ho, vo, he, ve, out_ready} = {10'h000, 16'h3c96, 1'b1};
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_write_rules();
    t_dummy();
    t_offset_skip();
    t_pixels();
    t_stall();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
